//--- rtl/fcl_regs.sv
`timescale 1ns/1ps
// Operation
// - config_one bits 7:6 select mode and dummy cycles before read data.
// - single-rate latency per code for fast, dual, quad reads.
// - double-rate latency per code for fast, dual and quad I/O reads.
// - protect_from_bottom chooses protection growing from top or bottom.
// - OTP placement bits only go 0 to 1; clearing while freeze is clear sets program fail.
// - protect_bits_volatile makes protect level volatile, resetting to 111.
// - parameter_sectors_top places small-sector block at top or bottom.
// - uniform sectors make parameter_sectors_top without effect.
// - protection and parameter placement are independent.
// - quad bit turns write-protect and hold into data lines 2 and 3.
// - serial and dual reads still work with quad bit set.
// - freeze blocks writes of protect level and placement bits; protect_bits_volatile can still be set.
// - freeze clear leaves config writable, including freeze itself.
// - freeze volatile, cleared only by power-on or hardware reset.
// - one register write may set freeze with other config bits.
// - status_two read by 07h, bits 7:2 zero, nothing writable.
// - status_two bit 1 shows erase suspend.
// - status_two bit 0 shows program suspend.
// - suspend flags follow 75h/7Ah and 85h/8Ah.
module fcl_regs (
  // system clock and power-on/hardware reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link, sck domain
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // pins shared with quad data, and sector layout select
  input wire logic wp_n_pin,
  input wire logic hold_n_pin,
  input wire logic uniform_sectors,
  // read latency query
  input wire logic double_rate,
  input wire fcl_pkg::fcl_read_kind_e read_kind,
  output logic [2:0] mode_cycles,
  output logic [3:0] dummy_cycles,
  // protection and layout state
  output logic [7:0] config_one,
  output logic [7:0] status_one,
  output logic [7:0] status_two,
  output logic protect_from_bottom,
  output logic parameter_sectors_top,
  output logic params_at_top,
  output logic quad_enable,
  output logic wp_n_eff,
  output logic hold_n_eff,
  output logic otp_locked
);
  import fcl_pkg::*;
  // ------------------------------------------------------------
  // link side: shift in command and data bytes on sck
  // ------------------------------------------------------------
  // frame ends with cs_n; counters cleared on cs_n so no edge after the frame is needed
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] data0_q;
  logic [7:0] data1_q;
  logic cfg_seen_q;
  logic req_tgl_q;
  logic [7:0] rd_shift_q;
  logic [7:0] snap_status_one;
  logic [7:0] snap_config_one;
  logic [7:0] snap_status_two;
  logic [7:0] byte_in;
  assign byte_in = {shift_q[6:0], si};
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 2'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7 && byte_cnt_q != 2'h3) begin
        byte_cnt_q <= byte_cnt_q + 2'h1;
      end
    end
  end
  always_ff @(posedge sck) begin
    shift_q <= byte_in;
    if (bit_cnt_q == 3'h7) begin
      unique case (byte_cnt_q)
        2'h0: begin
          cmd_q <= byte_in;
          cfg_seen_q <= 1'b0;
        end
        2'h1: data0_q <= byte_in;
        2'h2: begin
          data1_q <= byte_in;
          cfg_seen_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  // request captured on the frame's rising cs_n, so no sck edge is needed after it
  always_ff @(posedge cs_n or posedge rst) begin
    if (rst) begin
      req_tgl_q <= 1'b0;
    end else if (byte_cnt_q != 2'h0) begin
      req_tgl_q <= ~req_tgl_q;
    end
  end
  // ------------------------------------------------------------
  // read data: register values sampled into the sck domain
  // ------------------------------------------------------------
  // quasi-static registers; a read racing a write may see a mixed byte
  assign snap_status_one = status_one;
  assign snap_config_one = config_one;
  assign snap_status_two = status_two;
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      rd_shift_q <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (byte_cnt_q == 2'h1 && bit_cnt_q == 3'h0) begin
      unique case (cmd_q)
        CMD_READ_STATUS_ONE: rd_shift_q <= {snap_status_one[6:0], 1'b0};
        CMD_READ_CONFIG_ONE: rd_shift_q <= {snap_config_one[6:0], 1'b0};
        CMD_STATUS_TWO_READ: rd_shift_q <= {snap_status_two[6:0], 1'b0};
        default: rd_shift_q <= 8'h00;
      endcase
      unique case (cmd_q)
        CMD_READ_STATUS_ONE: so <= snap_status_one[7];
        CMD_READ_CONFIG_ONE: so <= snap_config_one[7];
        CMD_STATUS_TWO_READ: so <= snap_status_two[7];
        default: so <= 1'b0;
      endcase
      so_oe <= (cmd_q == CMD_READ_STATUS_ONE) || (cmd_q == CMD_READ_CONFIG_ONE) ||
               (cmd_q == CMD_STATUS_TWO_READ);
    end else if (byte_cnt_q != 2'h0) begin
      so <= rd_shift_q[7];
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
    end
  end
  // ------------------------------------------------------------
  // crossing: toggle synchroniser into ref_clk
  // ------------------------------------------------------------
  logic req_sync;
  logic req_seen_q;
  logic cmd_pulse;
  fcl_sync u_sync_req (.clk(ref_clk), .in_level(req_tgl_q), .out_level(req_sync));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_seen_q <= 1'b0;
    end else begin
      req_seen_q <= req_sync;
    end
  end
  // bytes stay stable until the next frame, which is far slower than the crossing
  assign cmd_pulse = req_sync ^ req_seen_q;
  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic wp_sync;
  logic is_write;
  logic is_soft_reset;
  logic [7:0] new_status;
  logic [7:0] new_config;
  logic otp_clear_try;
  logic freeze_q;
  logic [7:0] cfg_q;
  logic [2:0] bp_q;
  logic [2:0] bp_nv_q;
  logic prog_fail_q;
  logic erase_susp_q;
  logic prog_susp_q;
  logic [7:0] cfg_d;
  logic [2:0] bp_d;
  assign is_write = cmd_pulse && (cmd_q == CMD_REGISTER_WRITE);
  assign is_soft_reset = cmd_pulse && (cmd_q == CMD_SOFT_RESET);
  assign new_status = data0_q;
  // the frame's own flag, not the byte value, says whether a config byte came; zero is a legal value
  assign new_config = cfg_seen_q ? data1_q : cfg_q;
  assign otp_clear_try = |(cfg_q & ~new_config & CONFIG_OTP_MASK);
  // freeze bits locked; OTP bits may only rise; others written as given
  always_comb begin
    cfg_d = cfg_q;
    bp_d = bp_q;
    if (is_write) begin
      cfg_d[CFG_LATENCY_HI:CFG_LATENCY_LO] = new_config[CFG_LATENCY_HI:CFG_LATENCY_LO];
      cfg_d[CFG_QUAD] = new_config[CFG_QUAD];
      cfg_d[CFG_FREEZE] = cfg_q[CFG_FREEZE] | new_config[CFG_FREEZE];
      if (!freeze_q) begin
        cfg_d[CFG_PROTECT_FROM_BOTTOM] = cfg_q[CFG_PROTECT_FROM_BOTTOM] |
                                         new_config[CFG_PROTECT_FROM_BOTTOM];
        cfg_d[CFG_PARAMETER_SECTORS_TOP] = cfg_q[CFG_PARAMETER_SECTORS_TOP] |
                                           new_config[CFG_PARAMETER_SECTORS_TOP];
        bp_d = new_status[ST1_BP_HI:ST1_BP_LO];
      end
      cfg_d[CFG_PROTECT_BITS_VOLATILE] = cfg_q[CFG_PROTECT_BITS_VOLATILE] |
                                         new_config[CFG_PROTECT_BITS_VOLATILE];
    end
  end
  // ------------------------------------------------------------
  // registers on ref_clk
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q <= CONFIG_ONE_RESET;
      freeze_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d & CONFIG_WRITABLE_MASK;
      freeze_q <= cfg_d[CFG_FREEZE];
    end
  end
  // bp nonvolatile copy kept so a volatile reload does not lose it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bp_nv_q <= BP_RESET;
      bp_q <= BP_RESET;
    end else if (is_soft_reset) begin
      bp_q <= cfg_q[CFG_PROTECT_BITS_VOLATILE] ? BP_VOLATILE_RESET : bp_nv_q;
    end else begin
      bp_q <= bp_d;
      if (!cfg_q[CFG_PROTECT_BITS_VOLATILE] && is_write && !freeze_q) begin
        bp_nv_q <= bp_d;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_fail_q <= 1'b0;
    end else if (is_write && otp_clear_try && !freeze_q) begin
      prog_fail_q <= 1'b1;
    end else if (cmd_pulse && (cmd_q == CMD_CLEAR_STATUS || is_soft_reset)) begin
      prog_fail_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || is_soft_reset) begin
      erase_susp_q <= 1'b0;
      prog_susp_q <= 1'b0;
    end else if (cmd_pulse) begin
      if (cmd_q == CMD_ERASE_SUSPEND) begin
        erase_susp_q <= 1'b1;
      end else if (cmd_q == CMD_ERASE_RESUME) begin
        erase_susp_q <= 1'b0;
      end
      if (cmd_q == CMD_PROGRAM_SUSPEND) begin
        prog_susp_q <= 1'b1;
      end else if (cmd_q == CMD_PROGRAM_RESUME) begin
        prog_susp_q <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // pins and latency
  // ------------------------------------------------------------
  logic hold_sync;
  logic [2:0] mode_w;
  logic [3:0] dummy_w;
  logic [7:0] config_one_d;
  logic [7:0] status_one_d;
  logic [7:0] status_two_d;
  logic params_at_top_d;
  logic wp_n_eff_d;
  logic hold_n_eff_d;
  fcl_sync u_sync_wp (.clk(ref_clk), .in_level(wp_n_pin), .out_level(wp_sync));
  fcl_sync u_sync_hold (.clk(ref_clk), .in_level(hold_n_pin), .out_level(hold_sync));
  fcl_latency u_latency (
    .latency_select(cfg_q[CFG_LATENCY_HI:CFG_LATENCY_LO]),
    .double_rate(double_rate),
    .kind(read_kind),
    .mode_cycles(mode_w),
    .dummy_cycles(dummy_w)
  );
  // register images as the host reads them
  assign config_one_d = {cfg_q[7:1], freeze_q};
  assign status_one_d = {1'b0, prog_fail_q, 1'b0, bp_q, 2'h0};
  assign status_two_d = {6'h00, erase_susp_q, prog_susp_q};
  // uniform layout has no small sectors, so the placement bit is ignored there
  assign params_at_top_d = cfg_q[CFG_PARAMETER_SECTORS_TOP] && !uniform_sectors;
  // in quad mode the pins carry data, so their control meaning reads inactive
  assign wp_n_eff_d = cfg_q[CFG_QUAD] ? 1'b1 : wp_sync;
  assign hold_n_eff_d = cfg_q[CFG_QUAD] ? 1'b1 : hold_sync;
  // ------------------------------------------------------------
  // latency outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_cycles <= 3'h0;
      dummy_cycles <= 4'h0;
    end else begin
      mode_cycles <= mode_w;
      dummy_cycles <= dummy_w;
    end
  end
  // ------------------------------------------------------------
  // register image outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      config_one <= CONFIG_ONE_RESET;
      status_one <= 8'h00;
      status_two <= 8'h00;
      otp_locked <= 1'b0;
    end else begin
      config_one <= config_one_d;
      status_one <= status_one_d;
      status_two <= status_two_d;
      otp_locked <= freeze_q;
    end
  end
  // ------------------------------------------------------------
  // placement and pin outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      protect_from_bottom <= 1'b0;
      parameter_sectors_top <= 1'b0;
      params_at_top <= 1'b0;
      quad_enable <= 1'b0;
    end else begin
      protect_from_bottom <= cfg_q[CFG_PROTECT_FROM_BOTTOM];
      parameter_sectors_top <= cfg_q[CFG_PARAMETER_SECTORS_TOP];
      params_at_top <= params_at_top_d;
      quad_enable <= cfg_q[CFG_QUAD];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wp_n_eff <= 1'b1;
      hold_n_eff <= 1'b1;
    end else begin
      wp_n_eff <= wp_n_eff_d;
      hold_n_eff <= hold_n_eff_d;
    end
  end
endmodule

//--- rtl/fcl_pkg.sv
package fcl_pkg;
  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] CMD_STATUS_TWO_READ = 8'h07;
  localparam logic [7:0] CMD_READ_CONFIG_ONE = 8'h35;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;
  localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h7A;
  localparam logic [7:0] CMD_PROGRAM_SUSPEND = 8'h85;
  localparam logic [7:0] CMD_PROGRAM_RESUME = 8'h8A;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_ENTER_UNIFORM = 8'hC7;
  // ------------------------------------------------------------
  // config_one and status_one field positions
  // ------------------------------------------------------------
  localparam int CFG_LATENCY_HI = 7;
  localparam int CFG_LATENCY_LO = 6;
  localparam int CFG_PROTECT_FROM_BOTTOM = 5;
  localparam int CFG_PROTECT_BITS_VOLATILE = 3;
  localparam int CFG_PARAMETER_SECTORS_TOP = 2;
  localparam int CFG_QUAD = 1;
  localparam int CFG_FREEZE = 0;
  localparam int ST1_PROGRAM_FAIL = 6;
  localparam int ST1_BP_HI = 4;
  localparam int ST1_BP_LO = 2;
  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_OTP_MASK = 8'h2C;
  localparam logic [7:0] CONFIG_WRITABLE_MASK = 8'hEF;
  localparam logic [2:0] BP_VOLATILE_RESET = 3'h7;
  localparam logic [2:0] BP_RESET = 3'h0;
  // ------------------------------------------------------------
  // read kinds for latency lookup
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    FCL_RD_FAST = 3'h0,
    FCL_RD_DUAL_OUT = 3'h1,
    FCL_RD_QUAD_OUT = 3'h2,
    FCL_RD_DUAL_IO = 3'h3,
    FCL_RD_QUAD_IO = 3'h4
  } fcl_read_kind_e;
  typedef enum logic [4:0] {
    FCL_ST_IDLE = 5'h01,
    FCL_ST_CMD = 5'h02,
    FCL_ST_DATA_IN = 5'h04,
    FCL_ST_DATA_OUT = 5'h08,
    FCL_ST_DONE = 5'h10
  } fcl_state_e;
endpackage

//--- rtl/fcl_sync.sv
`timescale 1ns/1ps
module fcl_sync (
  // clock
  input wire logic clk,
  // level
  input wire logic in_level,
  output logic out_level
);
  logic meta_q;
  always_ff @(posedge clk) begin
    meta_q <= in_level;
    out_level <= meta_q;
  end
endmodule

//--- rtl/fcl_latency.sv
`timescale 1ns/1ps
module fcl_latency (
  // selection
  input wire logic [1:0] latency_select,
  input wire logic double_rate,
  input wire fcl_pkg::fcl_read_kind_e kind,
  // result
  output logic [2:0] mode_cycles,
  output logic [3:0] dummy_cycles
);
  import fcl_pkg::*;
  // ------------------------------------------------------------
  // sdr and ddr tables, code order 11/00/01/10
  // ------------------------------------------------------------
  always_comb begin
    mode_cycles = 3'h0;
    dummy_cycles = 4'h0;
    if (double_rate) begin
      unique case (kind)
        FCL_RD_DUAL_IO: begin
          mode_cycles = 3'h2;
          unique case (latency_select)
            2'h3: dummy_cycles = 4'h2;
            2'h0: dummy_cycles = 4'h4;
            2'h1: dummy_cycles = 4'h5;
            default: dummy_cycles = 4'h6;
          endcase
        end
        FCL_RD_QUAD_IO: begin
          mode_cycles = 3'h1;
          unique case (latency_select)
            2'h3: dummy_cycles = 4'h3;
            2'h0: dummy_cycles = 4'h6;
            2'h1: dummy_cycles = 4'h7;
            default: dummy_cycles = 4'h8;
          endcase
        end
        default: begin
          mode_cycles = 3'h4;
          unique case (latency_select)
            2'h3: dummy_cycles = 4'h1;
            2'h0: dummy_cycles = 4'h2;
            2'h1: dummy_cycles = 4'h4;
            default: dummy_cycles = 4'h5;
          endcase
        end
      endcase
    end else begin
      unique case (kind)
        FCL_RD_DUAL_IO: begin
          mode_cycles = 3'h4;
          unique case (latency_select)
            2'h3, 2'h0: dummy_cycles = 4'h0;
            2'h1: dummy_cycles = 4'h1;
            default: dummy_cycles = 4'h2;
          endcase
        end
        FCL_RD_QUAD_IO: begin
          mode_cycles = 3'h2;
          unique case (latency_select)
            2'h3: dummy_cycles = 4'h1;
            2'h2: dummy_cycles = 4'h5;
            default: dummy_cycles = 4'h4;
          endcase
        end
        default: dummy_cycles = (latency_select == 2'h3) ? 4'h0 : 4'h8;
      endcase
    end
  end
endmodule

//--- testbench/fcl_regs_sva.sv
`timescale 1ns/1ps
module fcl_regs_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // inputs watched
  input wire logic cs_n,
  input wire logic uniform_sectors,
  input wire logic double_rate,
  input wire fcl_pkg::fcl_read_kind_e read_kind,
  // outputs watched
  input wire logic [2:0] mode_cycles,
  input wire logic [3:0] dummy_cycles,
  input wire logic [7:0] config_one,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  input wire logic parameter_sectors_top,
  input wire logic params_at_top,
  input wire logic quad_enable,
  input wire logic wp_n_eff,
  input wire logic hold_n_eff
);
  import fcl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  lat_fast_a:
    assert property ((!double_rate && read_kind == FCL_RD_FAST && config_one[7:6] != 2'h3)[*3]
      |-> mode_cycles == 3'h0 && dummy_cycles == 4'h8) else $error("fast read latency wrong");
  lat_quad_a:
    assert property ((!double_rate && read_kind == FCL_RD_QUAD_IO && config_one[7:6] == 2'h3)[*3]
      |-> mode_cycles == 3'h2 && dummy_cycles == 4'h1) else $error("quad io latency wrong");
  lat_ddr_a:
    assert property ((double_rate && read_kind == FCL_RD_QUAD_IO && config_one[7:6] == 2'h2)[*3]
      |-> mode_cycles == 3'h1 && dummy_cycles == 4'h8) else $error("ddr quad latency wrong");
  otp_sticky_a:
    assert property ((|($past(config_one) & CONFIG_OTP_MASK & ~config_one)) |-> $past(rst) || $past(rst, 2))
    else $error("one-time bit cleared");
  freeze_hold_a:
    assert property (config_one[0] && $past(config_one[0]) |-> $stable(config_one[5]) && $stable(config_one[2]))
    else $error("placement bit moved while frozen");
  freeze_clear_a:
    assert property ($fell(config_one[0]) |-> $past(rst) || $past(rst, 2)) else $error("freeze cleared");
  quad_pins_a:
    assert property (quad_enable[*4] |-> wp_n_eff && hold_n_eff) else $error("pins active in quad");
  uniform_param_a:
    assert property (uniform_sectors[*4] |-> !params_at_top) else $error("parameter block in uniform");
  param_top_a:
    assert property ((!uniform_sectors && parameter_sectors_top)[*4] |-> params_at_top)
    else $error("parameter block not at top");
  st2_reserved_a:
    assert property (status_two[7:2] == 6'h00) else $error("status two reserved bits set");
  quiet_regs_a:
    assert property ((cs_n && !rst)[*8] |=> $stable(status_two) && $stable(config_one) && $stable(status_one))
    else $error("registers changed without command");
endmodule

bind fcl_regs fcl_regs_sva i_sva (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
  .uniform_sectors(uniform_sectors), .double_rate(double_rate), .read_kind(read_kind),
  .mode_cycles(mode_cycles), .dummy_cycles(dummy_cycles), .config_one(config_one),
  .status_one(status_one), .status_two(status_two), .parameter_sectors_top(parameter_sectors_top),
  .params_at_top(params_at_top), .quad_enable(quad_enable), .wp_n_eff(wp_n_eff), .hold_n_eff(hold_n_eff));

//--- testbench/fcl_host_model.sv
`timescale 1ns/1ps
module fcl_host_model (
  // link to device
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  initial begin
    sck = 1'b0;
    si = 1'b0;
    // a deselect edge after time zero puts the link counters in a known state
    cs_n = 1'b0;
    #1;
    cs_n = 1'b1;
  end
  // sck rests low outside frames; reads are sampled on the rising edge
  task automatic xfer(input logic [23:0] bits, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = bits[23 - i];
      #40;
      sck = 1'b1;
      rd = {rd[6:0], so_oe ? so : 1'bx};
      #40;
      sck = 1'b0;
    end
    // released line must not keep showing the last bit
    si = ~si;
    #40;
    cs_n = 1'b1;
  endtask
endmodule

//--- testbench/fcl_regs_tb.sv
`timescale 1ns/1ps
module fcl_regs_tb;
  import fcl_pkg::*;
  logic ref_clk, rst, sck, cs_n, si, so, so_oe, wp_n_pin, hold_n_pin, uniform_sectors, double_rate;
  fcl_read_kind_e read_kind;
  logic [2:0] mode_cycles;
  logic [3:0] dummy_cycles;
  logic [7:0] config_one, status_one, status_two, rd;
  logic protect_from_bottom, parameter_sectors_top, params_at_top, quad_enable, wp_n_eff, hold_n_eff, otp_locked;
  int num_errors = 0;
  int tests_run = 0;
  fcl_regs i_dut (.ref_clk(ref_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .wp_n_pin(wp_n_pin), .hold_n_pin(hold_n_pin), .uniform_sectors(uniform_sectors),
    .double_rate(double_rate), .read_kind(read_kind), .mode_cycles(mode_cycles), .dummy_cycles(dummy_cycles),
    .config_one(config_one), .status_one(status_one), .status_two(status_two),
    .protect_from_bottom(protect_from_bottom), .parameter_sectors_top(parameter_sectors_top),
    .params_at_top(params_at_top), .quad_enable(quad_enable), .wp_n_eff(wp_n_eff), .hold_n_eff(hold_n_eff),
    .otp_locked(otp_locked));
  fcl_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset(input int n);
    rst = 1'b1;
    cyc(n);
    rst = 1'b0;
    cyc(2);
  endtask
  // gap covers the execute crossing and the minimum frame spacing
  task automatic wr(input logic [7:0] st, input logic [7:0] cfg);
    i_host.xfer({CMD_REGISTER_WRITE, st, cfg}, 24, rd);
    cyc(12);
  endtask
  task automatic cmd(input logic [7:0] c, input int nbits);
    i_host.xfer({c, 16'h0000}, nbits, rd);
    cyc(12);
  endtask
  function automatic logic [7:0] lat(input int k, input int lc);
    case (k)
      0, 1, 2: return {4'h0, (lc == 3) ? 4'h0 : 4'h8};
      3: return {4'h4, (lc == 3) ? 4'h0 : 4'(lc)};
      4: return {4'h2, 4'(lc == 3 ? 1 : (lc == 2 ? 5 : 4))};
      5: return {4'h4, 4'(lc == 3 ? 1 : (lc == 0 ? 2 : lc + 3))};
      6: return {4'h2, 4'(lc == 3 ? 2 : lc + 4)};
      default: return {4'h1, 4'(lc == 3 ? 3 : lc + 6)};
    endcase
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_latency;
    for (int lc = 0; lc < 4; lc++) begin
      wr(8'h00, {2'(lc), 6'h00});
      chk(config_one, {2'(lc), 6'h00});
      for (int k = 0; k < 8; k++) begin
        double_rate = (k > 4);
        read_kind = fcl_read_kind_e'(3'(k < 5 ? k : (k == 5 ? 0 : k - 3)));
        cyc(3);
        chk({1'b0, mode_cycles, dummy_cycles}, lat(k, lc));
      end
    end
    cmd(CMD_READ_CONFIG_ONE, 16);
    chk(rd, 8'hC0);
    // training-pattern host picks a code giving ddr fast read five dummies
    wr(8'h00, 8'h80);
    double_rate = 1'b1;
    read_kind = FCL_RD_FAST;
    cyc(3);
    chk({4'h0, dummy_cycles}, 8'h05);
  endtask
  task automatic t_quad;
    wp_n_pin = 1'b0;
    hold_n_pin = 1'b0;
    wr(8'h00, 8'h02);
    chk({5'h0, quad_enable, wp_n_eff, hold_n_eff}, 8'h07);
    cmd(CMD_READ_CONFIG_ONE, 16);
    chk(rd, 8'h02);
    wr(8'h00, 8'h00);
    chk({5'h0, quad_enable, wp_n_eff, hold_n_eff}, 8'h00);
    wp_n_pin = 1'b1;
    hold_n_pin = 1'b1;
    cyc(4);
  endtask
  task automatic t_suspend;
    logic [7:0] c [4] = '{CMD_ERASE_SUSPEND, CMD_PROGRAM_SUSPEND, CMD_ERASE_RESUME, CMD_PROGRAM_RESUME};
    logic [7:0] e [4] = '{8'h02, 8'h03, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      cmd(c[i], 8);
      chk(status_two, e[i]);
      cmd(CMD_STATUS_TWO_READ, 16);
      chk(rd, e[i]);
    end
  endtask
  task automatic t_otp;
    wr(8'h0C, 8'h00);
    cmd(CMD_SOFT_RESET, 8);
    chk({5'h0, status_one[4:2]}, 8'h03);
    // placement fixed before any array access
    wr(8'h0C, 8'h20);
    chk({5'h0, protect_from_bottom, parameter_sectors_top, params_at_top}, 8'h04);
    wr(8'h0C, 8'h2C);
    chk({5'h0, protect_from_bottom, parameter_sectors_top, params_at_top}, 8'h07);
    uniform_sectors = 1'b1;
    cyc(4);
    chk({7'h0, params_at_top}, 8'h00);
    uniform_sectors = 1'b0;
    wr(8'h0C, 8'h02);
    chk(config_one, 8'h2E);
    chk({7'h0, status_one[6]}, 8'h01);
    cmd(CMD_CLEAR_STATUS, 8);
    chk({7'h0, status_one[6]}, 8'h00);
    cmd(CMD_SOFT_RESET, 8);
    chk({5'h0, status_one[4:2]}, 8'h07);
  endtask
  task automatic t_freeze;
    wr(8'h1C, 8'h6F);
    chk(config_one, 8'h6F);
    wr(8'h00, 8'hEE);
    chk(config_one, 8'hEF);
    chk({5'h0, status_one[4:2]}, 8'h07);
    chk({7'h0, otp_locked}, 8'h01);
    cmd(CMD_SOFT_RESET, 8);
    chk({7'h0, config_one[0]}, 8'h01);
    do_reset(2);
    chk(config_one, CONFIG_ONE_RESET);
  endtask
  initial begin
    rst = 1'b1;
    wp_n_pin = 1'b1;
    hold_n_pin = 1'b1;
    uniform_sectors = 1'b0;
    double_rate = 1'b0;
    read_kind = FCL_RD_FAST;
    do_reset(6);
    chk(config_one, CONFIG_ONE_RESET);
    chk(status_two, 8'h00);
    chk({6'h0, wp_n_eff, hold_n_eff}, 8'h03);
    t_latency;
    t_quad;
    t_suspend;
    t_otp;
    t_freeze;
    end_sim;
  end
  initial begin
    #400us;
    num_errors++;
    end_sim;
  end
endmodule
